// *** mss_pkg.sv ***
// Package: shared types and constants for the motion status flag block
package mss_pkg;
   localparam int POS_W = 32;
   localparam logic ZERO_BIT = 1'h0;
   localparam logic [POS_W-1:0] POS_ZERO = 32'h0000_0000;
   localparam logic [7:0] ASSIGN_NONE = 8'h00;

   // Raw external pins
   typedef struct packed {
      logic neg_limit_input;
      logic pos_limit_input;
      logic origin_sensor_input;
      logic home_request_input;
      logic current_off_input;
      logic hold_input;
      logic hold_abandon_input;
      logic fault_clear_input;
   } mss_pins_t;

   // Active level settings, 1 means normally closed
   typedef struct packed {
      logic overtravel_polarity;
      logic origin_sensor_polarity;
      logic home_request_polarity;
      logic current_off_polarity;
      logic hold_polarity;
      logic hold_abandon_polarity;
      logic fault_clear_polarity;
      logic fault_output_polarity;
      logic zone_output_polarity;
      logic at_origin_polarity;
      logic motion_active_polarity;
   } mss_levels_t;

   // Reported status flags
   typedef struct packed {
      logic fault_flag;
      logic fault_clear_flag;
      logic zone_flag;
      logic current_off_flag;
      logic home_request_flag;
      logic at_origin_flag;
      logic origin_sensor_flag;
      logic neg_limit_flag;
      logic pos_limit_flag;
      logic motion_active_flag;
      logic hold_flag;
   } mss_flags_t;

   // Driven output pins
   typedef struct packed {
      logic fault_out;
      logic zone_out;
      logic at_origin_out;
      logic motion_active_out;
   } mss_outs_t;

   localparam int PIN_N = $bits(mss_pins_t);
endpackage

// *** mss_sync.sv ***
// Two flip-flop synchroniser bank for the external sensor pins
module mss_sync
   import mss_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire logic [PIN_N-1:0] async_in,
   output logic      [PIN_N-1:0] sync_out
);
   logic [PIN_N-1:0] stage1;

   generate
      for (genvar i = 0; i < PIN_N; i++)
      begin : g_bit
         always_ff @(posedge mclk or posedge sys_rst)
         begin
            if (sys_rst)
            begin
               stage1[i]   <= ZERO_BIT;
               sync_out[i] <= ZERO_BIT;
            end
            else
            begin
               stage1[i]   <= async_in[i];
               sync_out[i] <= stage1[i];
            end
         end
      end
   endgenerate
endmodule

// *** mss_status.sv ***
// Motion status flag logic: qualifies sensor pins and motion state into flags
// What this block does
// - Fault flag is 1 while any fault condition is active, else 0.
// - Any fault aborts all running sequences immediately.
// - Fault output pin polarity set by its own level setting.
// - Fault force command raises the fault; fault clear removes it.
// - Fault clear flag shows the qualified fault clear input, read only.
// - Zone flag is set while position lies between the two zone bounds.
// - Zone output and every other status signal have own level settings, except the two limit inputs, which share one.
// - Current off flag follows the input only; zero when software disabled current.
// - Home request turning on starts homing; its flag follows the input.
// - At origin flag is 0 until homing succeeds, then position equals zero.
// - Origin sensor used in three-sensor homing; flag shows sensor state.
// - Negative limit flag follows its input if assigned, else 0.
// - Positive limit flag follows its input if assigned, else 0.
// - One overtravel level setting serves both limit inputs.
// - Motion active flag is 1 while commanded position counter changes.
// - Hold flag is 1 only when hold is assigned and asserted.
// - Hold input decelerates motion to stop, remainder stays resumable.
// - Hold abandon input or command discards the paused remainder.
module mss_status
   import mss_pkg::*;
(
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   input  wire mss_pins_t        pins,
   input  wire mss_levels_t      levels,
   input  wire logic             neg_limit_assigned,
   input  wire logic             pos_limit_assigned,
   input  wire logic [7:0]       hold_input_assignment,
   input  wire logic             fault_condition,
   input  wire logic             fault_force_command,
   input  wire logic             fault_clear_command,
   input  wire logic             current_enabled,
   input  wire logic             three_sensor_mode,
   input  wire logic             homing_done,
   input  wire logic             homing_failed,
   input  wire logic             resume_command,
   input  wire logic             start_input,
   input  wire logic             sequence_running,
   input  wire logic             hold_abandon_command,
   input  wire logic             hold_command,
   input  wire logic             motion_start,
   input  wire logic [POS_W-1:0] position_counter,
   input  wire logic [POS_W-1:0] zone_bound_a,
   input  wire logic [POS_W-1:0] zone_bound_b,
   output mss_flags_t            flags,
   output mss_outs_t             outs,
   output logic                  sequence_abort,
   output logic                  homing_start,
   output logic                  origin_detect,
   output logic                  motion_decelerate,
   output logic                  motion_resume,
   output logic                  motion_discard,
   output logic                  paused
);
   mss_pins_t        sync_pins;
   logic             fault_forced;
   logic             fault_active;
   logic             fault_clear_q;
   logic             home_req_q;
   logic             home_req_prev;
   logic             homed;
   logic             hold_q;
   logic             hold_prev;
   logic [POS_W-1:0] pos_prev;
   logic             zone_in;
   logic             moving;
   logic             at_origin;
   logic [2:0]       armed;

   // Qualify a raw level with its active level setting
   function automatic logic qualify(input logic raw, input logic lvl);
      qualify = raw ^ lvl;
   endfunction

   // Signed inclusive range test, bounds in either order
   function automatic logic in_range(input logic [POS_W-1:0] p,
                                     input logic [POS_W-1:0] a,
                                     input logic [POS_W-1:0] b);
      logic signed [POS_W-1:0] sp;
      logic signed [POS_W-1:0] sa;
      logic signed [POS_W-1:0] sb;
      sp = signed'(p);
      sa = signed'(a);
      sb = signed'(b);
      if (sa <= sb)
         in_range = (sp >= sa) && (sp <= sb);
      else
         in_range = (sp >= sb) && (sp <= sa);
   endfunction

   mss_sync u_sync
   (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in (pins),
      .sync_out (sync_pins)
   );

   // Qualified input levels
   assign fault_clear_q = qualify(sync_pins.fault_clear_input,
                                  levels.fault_clear_polarity);
   assign home_req_q    = qualify(sync_pins.home_request_input,
                                  levels.home_request_polarity);
   assign hold_q        = (hold_input_assignment != ASSIGN_NONE)
                          && qualify(sync_pins.hold_input,
                                     levels.hold_polarity);

   // Internal state conditions
   assign fault_active = fault_condition || fault_forced;
   assign zone_in      = in_range(position_counter, zone_bound_a,
                                  zone_bound_b);
   assign moving       = (position_counter != pos_prev);
   assign at_origin    = homed && (position_counter == POS_ZERO);

   // Software forced fault; force wins over a same-cycle clear
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         fault_forced <= ZERO_BIT;
      else if (fault_force_command)
         fault_forced <= 1'h1;
      else if (fault_clear_command || fault_clear_q)
         fault_forced <= ZERO_BIT;
   end

   // Sequence abort follows any fault at once
   assign sequence_abort = fault_active;

   // Home request edge starts homing
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         home_req_prev <= ZERO_BIT;
      else
         home_req_prev <= home_req_q;
   end

   // Edge detectors wait until the synchronisers and their history hold real pin levels,
   // otherwise a normally closed input fakes a rising edge right after reset
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         armed <= '0;
      else
         armed <= {armed[1:0], 1'h1};
   end

   assign homing_start = armed[2] && home_req_q && !home_req_prev;

   // Origin sensor feeds three-sensor homing
   assign origin_detect = three_sensor_mode
                          && qualify(sync_pins.origin_sensor_input,
                                     levels.origin_sensor_polarity);

   // Home established once homing completes; a failed attempt drops it
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         homed <= ZERO_BIT;
      else if (homing_done)
         homed <= 1'h1;
      else if (homing_failed || homing_start)
         homed <= ZERO_BIT;
   end

   // Commanded position history for motion detection
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         pos_prev <= POS_ZERO;
      else
         pos_prev <= position_counter;
   end

   // Hold control
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         hold_prev <= ZERO_BIT;
      else
         hold_prev <= hold_q;
   end

   assign motion_decelerate = (armed[2] && hold_q && !hold_prev)
                              || hold_command;

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         paused <= ZERO_BIT;
      else if (motion_decelerate)
         paused <= 1'h1;
      else if (motion_resume || motion_discard || motion_start)
         paused <= ZERO_BIT;
   end

   assign motion_resume  = paused && (resume_command
                           || (sequence_running && start_input));
   assign motion_discard = paused && (hold_abandon_command
                           || qualify(sync_pins.hold_abandon_input,
                                      levels.hold_abandon_polarity));

   // Registered status flags
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         flags <= '0;
      else
      begin
         flags.fault_flag         <= fault_active;
         flags.fault_clear_flag   <= fault_clear_q;
         flags.zone_flag          <= zone_in;
         flags.current_off_flag   <= current_enabled
                                     && qualify(sync_pins.current_off_input,
                                                levels.current_off_polarity);
         flags.home_request_flag  <= home_req_q;
         flags.at_origin_flag     <= at_origin;
         flags.origin_sensor_flag <= qualify(sync_pins.origin_sensor_input,
                                             levels.origin_sensor_polarity);
         flags.neg_limit_flag     <= neg_limit_assigned
                                     && qualify(sync_pins.neg_limit_input,
                                                levels.overtravel_polarity);
         flags.pos_limit_flag     <= pos_limit_assigned
                                     && qualify(sync_pins.pos_limit_input,
                                                levels.overtravel_polarity);
         flags.motion_active_flag <= moving;
         flags.hold_flag          <= hold_q;
      end
   end

   // Physical outputs with their own polarity
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         outs <= '0;
      else
      begin
         outs.fault_out         <= qualify(fault_active,
                                           levels.fault_output_polarity);
         outs.zone_out          <= qualify(zone_in,
                                           levels.zone_output_polarity);
         outs.at_origin_out     <= qualify(at_origin,
                                           levels.at_origin_polarity);
         outs.motion_active_out <= qualify(moving,
                                           levels.motion_active_polarity);
      end
   end
endmodule

// *** mss_sensor.sv ***
// Contact model of the limit, origin, home, current-off, hold and fault-clear switches
module mss_sensor
   import mss_pkg::*;
(
   input  wire logic [7:0]  act,
   input  wire mss_levels_t levels,
   output mss_pins_t        pins
);
   timeunit 1ns;
   timeprecision 1ps;
   // Normally closed contacts idle high and open when active
   assign pins = act ^ {{2{levels.overtravel_polarity}}, levels.origin_sensor_polarity,
                        levels.home_request_polarity, levels.current_off_polarity,
                        levels.hold_polarity, levels.hold_abandon_polarity,
                        levels.fault_clear_polarity};
endmodule

// *** mss_chk.sv ***
// Checker of status flag timing against their sources
module mss_chk
   import mss_pkg::*;
(
   input wire logic             mclk,
   input wire logic             sys_rst,
   input wire mss_pins_t        pins,
   input wire mss_levels_t      levels,
   input wire logic             neg_limit_assigned,
   input wire logic [7:0]       hold_input_assignment,
   input wire logic             fault_condition,
   input wire logic             fault_force_command,
   input wire logic [POS_W-1:0] position_counter,
   input wire logic [POS_W-1:0] zone_bound_a,
   input wire logic [POS_W-1:0] zone_bound_b,
   input wire mss_flags_t       flags,
   input wire mss_outs_t        outs,
   input wire logic             three_sensor_mode,
   input wire logic             resume_command,
   input wire logic             hold_abandon_command,
   input wire logic             homing_start,
   input wire logic             origin_detect,
   input wire logic             motion_decelerate,
   input wire logic             paused,
   input wire logic             sequence_abort
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0]                   up;
   wire logic signed [POS_W-1:0] sp = position_counter;
   wire logic signed [POS_W-1:0] sa = zone_bound_a;
   wire logic signed [POS_W-1:0] sb = zone_bound_b;
   default clocking dc @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   // Edges since reset; pin paths are three stages deep
   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
         up <= 2'h0;
      else if (up != 2'h3)
         up <= up + 2'h1;
   end
   fault_lvl_a: assert property (fault_condition |=> flags.fault_flag)
      else $error("fault flag stayed low");
   abort_a: assert property (fault_condition |-> sequence_abort)
      else $error("no sequence abort on fault");
   fault_pin_a: assert property (up != 2'h0 |->
      outs.fault_out == (flags.fault_flag ^ levels.fault_output_polarity))
      else $error("fault pin level wrong");
   force_a: assert property (fault_force_command |=> sequence_abort ##1 flags.fault_flag)
      else $error("forced fault not seen");
   zone_a: assert property (up != 2'h0 |-> flags.zone_flag ==
      $past((sp >= sa && sp <= sb) || (sp >= sb && sp <= sa)))
      else $error("zone flag wrong");
   neg_lim_a: assert property (up == 2'h3 && $stable(neg_limit_assigned) |->
      flags.neg_limit_flag == (($past(pins.neg_limit_input, 3) ^ levels.overtravel_polarity)
      && neg_limit_assigned))
      else $error("negative limit flag wrong");
   hold_a: assert property (up == 2'h3 && $stable(hold_input_assignment) |->
      flags.hold_flag == (($past(pins.hold_input, 3) ^ levels.hold_polarity)
      && hold_input_assignment != ASSIGN_NONE))
      else $error("hold flag wrong");
   motion_a: assert property (up == 2'h3 |-> flags.motion_active_flag ==
      ($past(position_counter) != $past(position_counter, 2)))
      else $error("motion flag wrong");
   zone_pin_a: assert property (up != 2'h0 |->
      outs.zone_out == (flags.zone_flag ^ levels.zone_output_polarity))
      else $error("zone pin level wrong");
   origin_pin_a: assert property (up != 2'h0 |->
      outs.at_origin_out == (flags.at_origin_flag ^ levels.at_origin_polarity))
      else $error("origin pin level wrong");
   move_pin_a: assert property (up != 2'h0 |->
      outs.motion_active_out == (flags.motion_active_flag ^ levels.motion_active_polarity))
      else $error("motion pin level wrong");
   home_start_a: assert property (up == 2'h3 && $past(up) == 2'h3
      && $rose(flags.home_request_flag) |-> $past(homing_start))
      else $error("home request edge did not start homing");
   origin_use_a: assert property (up != 2'h0 |->
      $past(origin_detect) == ($past(three_sensor_mode) && flags.origin_sensor_flag))
      else $error("origin sensor not passed to homing");
   hold_stop_a: assert property (up == 2'h3 && $past(up) == 2'h3
      && $rose(flags.hold_flag) |-> $past(motion_decelerate))
      else $error("hold input did not stop motion");
   pause_set_a: assert property (motion_decelerate |=> paused)
      else $error("stop did not leave motion paused");
   pause_end_a: assert property (paused && !motion_decelerate
      && (resume_command || hold_abandon_command) |=> !paused)
      else $error("pause not ended by resume or abandon");
endmodule
bind mss_status mss_chk chk_u (.*);

// *** motion_status_signals_test.sv ***
// Bench for the status flag block: contacts, commands and position against flags
module motion_status_signals_test
   import mss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [3:0] FS [4] = '{4'h9, 4'h4, 4'h3, 4'h0};
   localparam logic [3:0] HS [5] = '{4'h0, 4'h5, 4'h8, 4'h1, 4'h2};
   logic             mclk, sys_rst, neg_limit_assigned, pos_limit_assigned, fault_condition;
   logic             fault_force_command, fault_clear_command, current_enabled, three_sensor_mode;
   logic             homing_done, homing_failed, resume_command, start_input, sequence_running;
   logic             hold_abandon_command, hold_command, motion_start, sequence_abort, paused;
   logic             homing_start, origin_detect, motion_decelerate, motion_resume, motion_discard;
   logic [7:0]       act, hold_input_assignment;
   logic [POS_W-1:0] position_counter, zone_bound_a, zone_bound_b, r;
   logic [21:0]      q[$];
   int               seed, err_count, n_checks, i;
   event             snap;
   mss_pins_t        pins;
   mss_levels_t      levels;
   mss_flags_t       flags;
   mss_outs_t        outs;
   mss_sensor sen_u (.act(act), .levels(levels), .pins(pins));
   mss_status dut_u (.*);
   initial
   begin
      mclk = 1'h0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input string name, input logic [10:0] seen, input logic [10:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic note(input logic [10:0] m, input logic [10:0] x);
      q.push_back({m, x});
      ->snap;
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Oldest note against the flags now on the port
   always @(snap)
   begin
      check("flags", flags & q[0][21:11], q[0][10:0]);
      void'(q.pop_front());
   end
   initial
   begin
      {neg_limit_assigned, pos_limit_assigned, fault_condition, fault_force_command,
       fault_clear_command, current_enabled, three_sensor_mode, homing_done, homing_failed,
       resume_command, start_input, sequence_running, hold_abandon_command, hold_command,
       motion_start, act, hold_input_assignment} = '0;
      seed = 62760;
      err_count = 0;
      n_checks = 0;
      sys_rst = 1'h1;
      r = $random(seed);
      levels = r[10:0];
      position_counter = 32'h0000_1388;
      zone_bound_a = 32'h0000_03E8;
      zone_bound_b = 32'hFFFF_FC18;
      tick(20);
      note(11'h7FF, 11'h000);
      sys_rst = 1'h0;
      tick(4);
      for (i = 0; i < 24; i++)
      begin
         r = $random(seed);
         {three_sensor_mode, start_input, sequence_running, resume_command, hold_command,
          hold_abandon_command, motion_start, neg_limit_assigned, pos_limit_assigned,
          current_enabled, act} = r[17:0];
         hold_input_assignment = {6'h00, r[19:18]};
         tick(1);
         {resume_command, hold_command, hold_abandon_command, motion_start} = 4'h0;
         tick(3);
         note(11'h7FF, {1'h0, act[0], 1'h0, act[3] & current_enabled, act[4], 1'h0,
                        act[5], act[7] & neg_limit_assigned, act[6] & pos_limit_assigned,
                        1'h0, act[2] & (hold_input_assignment != ASSIGN_NONE)});
      end
      act = 8'h00;
      {three_sensor_mode, start_input, sequence_running} = 3'h0;
      tick(4);
      // Force, clear, external fault, none
      for (i = 0; i < 4; i++)
      begin
         {fault_force_command, fault_clear_command, fault_condition} = FS[i][3:1];
         tick(1);
         {fault_force_command, fault_clear_command} = 2'h0;
         tick(1);
         note(11'h400, {FS[i][0], 10'h000});
      end
      fault_force_command = 1'h1;
      tick(1);
      fault_force_command = 1'h0;
      tick(1);
      sys_rst = 1'h1;
      tick(1);
      note(11'h7FF, 11'h000);
      sys_rst = 1'h0;
      tick(4);
      note(11'h7FF, 11'h000);
      repeat (6)
      begin
         position_counter = position_counter + 32'h0000_0001;
         tick(1);
      end
      note(11'h002, 11'h002);
      tick(2);
      note(11'h002, 11'h000);
      for (i = 0; i < 5; i++)
      begin
         position_counter = {29'h0, {3{HS[i][3]}}};
         {homing_done, homing_failed} = HS[i][2:1];
         tick(1);
         {homing_done, homing_failed} = 2'h0;
         tick(2);
         note(11'h120, {2'h0, 1'h1, 2'h0, HS[i][0], 5'h00});
      end
      stop_test();
   end
endmodule
